// *** fl_ctrl.sv ***
// single-wire control, mode logic and safety timer of the flash led driver
//
// Behaviour
// - line high enables the device, line low disables it
// - each pulse after the first on the line advances the data counter by one
// - an inactive high period after the pulses captures the counted word
// - a write is an address word followed by a data word
// - line low beyond 405 us shuts down and restores all registers to default
// - five serial-writable registers: flash, torch, duration, threshold, low battery
// - a rising edge on the flash trigger pin starts flash
// - flash ends with trigger pin low and flash register cleared, or when the safety timer expires
// - writing flash register at address 1 starts flash, value sets current
// - flash current defaults near 1 A and never exceeds 1.2 A
// - torch register at address 2 starts torch; cleared value or timeout ends
// - torch current defaults near 250 mA, at most 300 mA, set by fraction
// - current above threshold is cut when the programmed duration expires
// - boost enable follows led driver activation exactly
// - the data counter is cleared to zero when a word begins
// - high longer than the latch timeout latches into shadow address or data
// - data above the register maximum discards the whole frame
`default_nettype none
`include "fl_consts.svh"

module fl_ctrl import fl_pkg::*; #(
   parameter int END_CYC = `FL_TEND_CYC,
   parameter int STEP_CYC = `FL_STEP_CYC,
   parameter int CNT_W = 15
) (
   input wire logic clk, // 40 MHz block clock
   input wire logic rst, // asynchronous reset, active high
   input wire logic serial_enable_line, // single-wire enable and data pin
   input wire logic flash_trigger_pin, // hardware flash start pin
   output var logic device_enabled, // high outside shutdown
   output var logic flash_active, // flash mode running
   output var logic torch_active, // torch mode running
   output var logic led_driver_on, // led current sink enabled
   output var logic boost_enable, // boost converter enable
   output var fl_ma_t led_current_ma, // programmed led current in mA
   output var fl_regs_s reg_values, // current register contents
   output var logic safety_expired, // pulse when the safety timer cuts current
   output var logic frame_error // pulse when a frame is discarded
);
   localparam logic [CNT_W-1:0] END_L = CNT_W'(END_CYC);
   localparam logic [CNT_W-1:0] LAT_L = CNT_W'(`FL_TLAT_CYC);
   localparam logic [CNT_W-1:0] TOFF_L = CNT_W'(`FL_TOFF_CYC);
   localparam int STEP_W = $clog2(STEP_CYC + 1);
   localparam logic [STEP_W-1:0] STEP_L = STEP_W'(STEP_CYC - 1);

   // ==========================================================
   // decoding helpers
   function automatic logic [5:0] fl_max(input logic [5:0] a);
      case (a)
         `FL_ADDR_FLASH: fl_max = `FL_MAX_FLASH;
         `FL_ADDR_TORCH: fl_max = `FL_MAX_TORCH;
         `FL_ADDR_DUR: fl_max = `FL_MAX_DUR;
         `FL_ADDR_LB: fl_max = `FL_MAX_LB;
         `FL_ADDR_THR: fl_max = `FL_MAX_THR;
         default: fl_max = 6'h00;
      endcase
   endfunction

   function automatic fl_ma_t fl_scale(input logic [4:0] code, input logic [15:0] full_ma);
      logic [15:0] prod;
      prod = 16'(code) * full_ma;
      fl_scale = fl_ma_t'(prod / `FL_CODE_FULL);
   endfunction

   // ==========================================================
   // pin synchronisation and line interval counters
   logic sel_s;
   logic fen_s;
   logic sel_d_r;
   logic fen_d_r;
   logic [CNT_W-1:0] low_cnt_r;
   logic [CNT_W-1:0] high_cnt_r;

   fl_sync #(.W(2)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({serial_enable_line, flash_trigger_pin}),
      .q({sel_s, fen_s})
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_d_r <= 1'b0;
         fen_d_r <= 1'b0;
      end else begin
         sel_d_r <= sel_s;
         fen_d_r <= fen_s;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_r <= '0;
      end else if (sel_s) begin
         low_cnt_r <= '0;
      end else if (low_cnt_r != '1) begin
         low_cnt_r <= low_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_cnt_r <= '0;
      end else if (!sel_s) begin
         high_cnt_r <= '0;
      end else if (high_cnt_r != '1) begin
         high_cnt_r <= high_cnt_r + 1'b1;
      end
   end

   logic sel_rise;
   logic sel_fall;
   logic rise_ok;
   logic fen_rise;
   assign sel_rise = sel_s & ~sel_d_r;
   assign sel_fall = ~sel_s & sel_d_r;
   // a low shorter than the off time is a glitch and does not count
   assign rise_ok = sel_rise & (low_cnt_r >= TOFF_L);
   assign fen_rise = fen_s & ~fen_d_r;

   // ==========================================================
   // frame receiver
   fl_state_e state_r;
   logic [5:0] data_cnt_r;
   logic first_r;
   logic [1:0] words_r;
   fl_frame_s shadow_r;
   logic shut_go;
   logic latch_go;
   logic close_go;
   logic frame_ok;
   logic apply_r;

   assign shut_go = !sel_s && (low_cnt_r == END_L) && (state_r != FL_SHUT);
   assign latch_go = (state_r == FL_WORD) && sel_s && (high_cnt_r == LAT_L);
   assign close_go = (state_r == FL_GAP) && sel_s && (high_cnt_r == END_L);
   assign frame_ok = (words_r == 2'd2) && (shadow_r.addr >= `FL_ADDR_FLASH)
                     && (shadow_r.addr <= `FL_ADDR_THR)
                     && (shadow_r.data <= fl_max(shadow_r.addr));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= FL_SHUT;
      end else if (shut_go) begin
         state_r <= FL_SHUT;
      end else begin
         case (state_r)
            FL_SHUT: if (sel_s) state_r <= FL_IDLE;
            FL_IDLE: if (sel_fall) state_r <= FL_WORD;
            FL_WORD: begin
               if (latch_go) begin
                  state_r <= (words_r == 2'd2) ? FL_ERR : FL_GAP;
               end else if (!sel_s && low_cnt_r == LAT_L) begin
                  state_r <= FL_ERR;
               end
            end
            FL_GAP: begin
               if (sel_fall) begin
                  state_r <= FL_WORD;
               end else if (close_go) begin
                  state_r <= FL_IDLE;
               end
            end
            FL_ERR: if (sel_s && high_cnt_r == END_L) state_r <= FL_IDLE;
            default: state_r <= FL_SHUT;
         endcase
      end
   end

   // the first rise of a word only clears the counter, so n pulses carry n - 1 and zero is sendable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_cnt_r <= 6'h00;
         first_r <= 1'b0;
      end else if (sel_fall && (state_r == FL_IDLE || state_r == FL_GAP)) begin
         data_cnt_r <= 6'h00;
         first_r <= 1'b1;
      end else if (state_r == FL_WORD && rise_ok) begin
         first_r <= 1'b0;
         if (first_r) begin
            data_cnt_r <= 6'h00;
         end else if (data_cnt_r != 6'h3F) begin
            data_cnt_r <= data_cnt_r + 6'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         words_r <= 2'd0;
         shadow_r <= '0;
      end else if (state_r == FL_IDLE) begin
         words_r <= 2'd0;
      end else if (latch_go && words_r != 2'd2) begin
         words_r <= words_r + 2'd1;
         if (words_r == 2'd0) begin
            shadow_r.addr <= data_cnt_r;
         end else begin
            shadow_r.data <= data_cnt_r;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         apply_r <= 1'b0;
         frame_error <= 1'b0;
      end else begin
         apply_r <= close_go && frame_ok && !shut_go;
         frame_error <= (close_go && !frame_ok)
                        || (latch_go && words_r == 2'd2)
                        || (state_r == FL_WORD && !sel_s && low_cnt_r == LAT_L);
      end
   end

   // ==========================================================
   // register file, written only by closed valid frames and restored to defaults in shutdown
   logic flash_wr_on;
   logic torch_wr_on;
   assign flash_wr_on = apply_r && shadow_r.addr == `FL_ADDR_FLASH && shadow_r.data != 6'h00;
   assign torch_wr_on = apply_r && shadow_r.addr == `FL_ADDR_TORCH && shadow_r.data != 6'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_values <= {`FL_RST_FLASH, `FL_RST_TORCH, `FL_RST_DUR, `FL_RST_LB, `FL_RST_THR};
      end else if (state_r == FL_SHUT) begin
         reg_values <= {`FL_RST_FLASH, `FL_RST_TORCH, `FL_RST_DUR, `FL_RST_LB, `FL_RST_THR};
      end else if (apply_r) begin
         case (shadow_r.addr)
            `FL_ADDR_FLASH: reg_values.flash <= shadow_r.data[4:0];
            `FL_ADDR_TORCH: reg_values.torch <= shadow_r.data[4:0];
            `FL_ADDR_DUR: reg_values.duration <= shadow_r.data[2:0];
            `FL_ADDR_LB: reg_values.low_batt <= shadow_r.data[3:0];
            `FL_ADDR_THR: reg_values.threshold <= shadow_r.data[4:0];
            default: reg_values <= reg_values;
         endcase
      end
   end

   assign device_enabled = (state_r != FL_SHUT);

   // ==========================================================
   // flash and torch modes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flash_active <= 1'b0;
      end else if (state_r == FL_SHUT) begin
         flash_active <= 1'b0;
      end else if (fen_rise || flash_wr_on) begin
         flash_active <= 1'b1;
      end else if (safety_expired) begin
         flash_active <= 1'b0;
      end else if (!fen_s && reg_values.flash == 5'h00) begin
         flash_active <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         torch_active <= 1'b0;
      end else if (state_r == FL_SHUT) begin
         torch_active <= 1'b0;
      end else if (torch_wr_on) begin
         torch_active <= 1'b1;
      end else if (safety_expired || reg_values.torch == 5'h00) begin
         torch_active <= 1'b0;
      end
   end

   // a zero code with the pin driving flash falls back to the default level
   logic [4:0] flash_code;
   logic [4:0] torch_code;
   fl_ma_t sel_ma;
   fl_ma_t thr_ma;
   assign flash_code = (reg_values.flash != 5'h00) ? reg_values.flash : `FL_FLASH_DEF_CODE;
   assign torch_code = (reg_values.torch != 5'h00) ? reg_values.torch : `FL_TORCH_DEF_CODE;
   // full code 31 maps to the ceiling, so no code can exceed it
   assign sel_ma = flash_active ? fl_scale(flash_code, `FL_FLASH_MAX_MA)
                 : fl_scale(torch_code, `FL_TORCH_MAX_MA);
   assign thr_ma = fl_scale(reg_values.threshold, `FL_THR_STEP_MA * `FL_CODE_FULL);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         led_driver_on <= 1'b0;
         led_current_ma <= '0;
      end else begin
         led_driver_on <= flash_active || torch_active;
         led_current_ma <= (flash_active || torch_active) ? sel_ma : fl_ma_t'(0);
      end
   end

   assign boost_enable = led_driver_on;

   // ==========================================================
   // safety timer: duration code d allows d+1 steps above threshold
   logic [STEP_W-1:0] step_cnt_r;
   logic [2:0] step_idx_r;
   logic over_thr;
   logic mode_start;
   assign over_thr = (flash_active || torch_active) && (sel_ma > thr_ma);
   assign mode_start = fen_rise || flash_wr_on || torch_wr_on;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_cnt_r <= '0;
         step_idx_r <= 3'd0;
         safety_expired <= 1'b0;
      end else begin
         safety_expired <= 1'b0;
         if (!over_thr || mode_start || safety_expired) begin
            step_cnt_r <= '0;
            step_idx_r <= 3'd0;
         end else if (step_cnt_r == STEP_L) begin
            step_cnt_r <= '0;
            if (step_idx_r == reg_values.duration) begin
               safety_expired <= 1'b1;
            end else begin
               step_idx_r <= step_idx_r + 3'd1;
            end
         end else begin
            step_cnt_r <= step_cnt_r + 1'b1;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_boost;
      (flash_active || torch_active) |=> (boost_enable && led_driver_on);
   endproperty
   a_boost: assert property (p_boost) else $error("boost not following driver");

   property p_shutdown;
      shut_go |=> (state_r == FL_SHUT) ##1 (reg_values.flash == 5'h00 && !flash_active);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("long low did not shut down");

   property p_fen_start;
      (fen_rise && state_r != FL_SHUT && !shut_go) |=> flash_active;
   endproperty
   a_fen_start: assert property (p_fen_start) else $error("trigger edge missed");

   property p_flash_hold;
      (flash_active && fen_s && !safety_expired && state_r != FL_SHUT) |=> flash_active;
   endproperty
   a_flash_hold: assert property (p_flash_hold) else $error("flash ended early");

   property p_torch_off;
      (apply_r && shadow_r.addr == `FL_ADDR_TORCH && shadow_r.data == 6'h00) |=> ##1 !torch_active;
   endproperty
   a_torch_off: assert property (p_torch_off) else $error("torch not cleared");

   property p_count;
      (state_r == FL_WORD && rise_ok && !first_r && data_cnt_r < 6'h3F && !shut_go)
         |=> data_cnt_r == $past(data_cnt_r) + 6'h01;
   endproperty
   a_count: assert property (p_count) else $error("pulse not counted");

   property p_first;
      (state_r == FL_WORD && rise_ok && first_r && !shut_go) |=> data_cnt_r == 6'h00;
   endproperty
   a_first: assert property (p_first) else $error("first rise kept count");

   property p_latch;
      (latch_go && words_r == 2'd0 && !shut_go) |=> (state_r == FL_GAP && words_r == 2'd1);
   endproperty
   a_latch: assert property (p_latch) else $error("word not latched");

   property p_discard;
      (close_go && !frame_ok) |=> (!apply_r && frame_error) ##1 $stable(reg_values);
   endproperty
   a_discard: assert property (p_discard) else $error("bad frame applied");

   property p_clear;
      (sel_fall && state_r == FL_IDLE && !shut_go) |=> (data_cnt_r == 6'h00 && state_r == FL_WORD);
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared");

   property p_expire;
      safety_expired && !mode_start |=> (!flash_active && !torch_active) ##1 !led_driver_on;
   endproperty
   a_expire: assert property (p_expire) else $error("timeout did not cut led");
endmodule

`default_nettype wire

// *** fl_consts.svh ***
// timing, address, limit and reset constants of the flash led control block
`ifndef FL_CONSTS_SVH
`define FL_CONSTS_SVH

// ==========================================================
// timing, figures in their own units, cycles derived at 40 MHz
`define FL_CLK_NS 25
`define FL_TOFF_NS 100
`define FL_TLAT_US 97
`define FL_TEND_US 405
`define FL_STEP_US 156250
`define FL_TOFF_CYC ((`FL_TOFF_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_TLAT_CYC ((`FL_TLAT_US * 1000 + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_TEND_CYC ((`FL_TEND_US * 1000 + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_STEP_CYC ((`FL_STEP_US * 1000) / `FL_CLK_NS)

// ==========================================================
// register addresses as pulse counts
`define FL_ADDR_FLASH 6'h01
`define FL_ADDR_TORCH 6'h02
`define FL_ADDR_DUR 6'h03
`define FL_ADDR_LB 6'h04
`define FL_ADDR_THR 6'h05

// ==========================================================
// largest accepted data value per register
`define FL_MAX_FLASH 6'h1F
`define FL_MAX_TORCH 6'h1F
`define FL_MAX_DUR 6'h07
`define FL_MAX_LB 6'h09
`define FL_MAX_THR 6'h1F

// ==========================================================
// reset values and current scaling
`define FL_RST_FLASH 5'h00
`define FL_RST_TORCH 5'h00
`define FL_RST_DUR 3'h7
`define FL_RST_LB 4'h0
`define FL_RST_THR 5'h05
`define FL_FLASH_DEF_CODE 5'h1A
`define FL_TORCH_DEF_CODE 5'h1A
`define FL_FLASH_MAX_MA 16'h04B0
`define FL_TORCH_MAX_MA 16'h012C
`define FL_THR_STEP_MA 16'h0032
`define FL_CODE_FULL 16'h001F

`endif

// *** fl_pkg.sv ***
// types shared by the flash led control block
`default_nettype none

package fl_pkg;
   typedef enum logic [2:0] {FL_SHUT, FL_IDLE, FL_WORD, FL_GAP, FL_ERR} fl_state_e;

   typedef struct packed {
      logic [4:0] flash;
      logic [4:0] torch;
      logic [2:0] duration;
      logic [3:0] low_batt;
      logic [4:0] threshold;
   } fl_regs_s;

   typedef struct packed {
      logic [5:0] addr;
      logic [5:0] data;
   } fl_frame_s;

   typedef logic [10:0] fl_ma_t;
endpackage

`default_nettype wire

// *** fl_sync.sv ***
// two-stage synchroniser for asynchronous pin inputs
`default_nettype none

module fl_sync #(
   parameter int W = 1
) (
   input wire logic clk, // block clock
   input wire logic rst, // asynchronous reset, active high
   input wire logic [W-1:0] d, // asynchronous inputs
   output var logic [W-1:0] q // synchronised outputs
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

`default_nettype wire

// *** fl_host.sv ***
// host gpio model that drives the single-wire serial enable line
`default_nettype none

module fl_host #(
   parameter int END_CYC = 5000, // frame end interval in cycles
   parameter int GAP_CYC = 4000 // high time between address and data words
) (
   input wire logic clk, // block clock
   output var logic serial_enable_line // driven line, pushed-pull by the host
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // line starts low, as after power-up with the device shut down
   initial serial_enable_line = 1'b0;

   // every change lands a fixed 2 ns after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // ==========================================================
   // pulses of 8 cycles low and high: above the glitch filter, far below the latch time
   // the first rise only clears the device counter, so value n takes n + 1 pulses
   task automatic send_word(input int n);
      repeat (n + 1) begin
         serial_enable_line = 1'b0;
         step(8);
         serial_enable_line = 1'b1;
         step(8);
      end
   endtask

   // gap must exceed the latch time yet stay short of the end time
   task automatic frame(input int addr, input int data);
      send_word(addr);
      step(GAP_CYC);
      send_word(data);
      step(END_CYC + 20);
   endtask

   task automatic level(input logic v, input int n);
      serial_enable_line = v;
      step(n);
   endtask
endmodule

`default_nettype wire

// *** tb.sv ***
// self-checking testbench of the flash led single-wire control block
`default_nettype none

module tb;
   import fl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // shortened end time keeps above the 3880-cycle latch time
   localparam int END_CYC = 5000;
   localparam int STEP_CYC = 50;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic flash_trigger_pin = 1'b0;
   logic serial_enable_line;
   logic device_enabled;
   logic flash_active;
   logic torch_active;
   logic led_driver_on;
   logic boost_enable;
   logic safety_expired;
   logic frame_error;
   fl_ma_t led_current_ma;
   fl_regs_s reg_values;
   fl_regs_s exp_r;
   fl_regs_s last_r;
   fl_regs_s exp_q[$];
   int err_total = 0;
   int checks = 0;
   int fe_n = 0;
   int fe0;
   int d;
   int n;

   always #12.5 clk = ~clk;

   fl_host #(.END_CYC(END_CYC)) host (
      .clk(clk),
      .serial_enable_line(serial_enable_line)
   );

   fl_ctrl #(.END_CYC(END_CYC), .STEP_CYC(STEP_CYC)) i_fl_ctrl (
      .clk(clk),
      .rst(rst),
      .serial_enable_line(serial_enable_line),
      .flash_trigger_pin(flash_trigger_pin),
      .device_enabled(device_enabled),
      .flash_active(flash_active),
      .torch_active(torch_active),
      .led_driver_on(led_driver_on),
      .boost_enable(boost_enable),
      .led_current_ma(led_current_ma),
      .reg_values(reg_values),
      .safety_expired(safety_expired),
      .frame_error(frame_error)
   );

   // ==========================================================
   // checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================================
   // monitor: any register change must match the oldest note
   always @(posedge clk) begin
      if (rst) begin
         last_r <= reg_values;
      end else if (reg_values !== last_r) begin
         last_r <= reg_values;
         if (exp_q.size() > 0) begin
            check(32'(reg_values), 32'(exp_q.pop_front()));
         end else begin
            check(32'(reg_values), 32'(last_r));
         end
      end
      if (frame_error === 1'b1) begin
         fe_n++;
      end
   end

   // notes only real changes, so a rewrite of the same value queues nothing
   task automatic note(input fl_regs_s v);
      if (v !== exp_r) begin
         exp_q.push_back(v);
      end
      exp_r = v;
   endtask

   task automatic wr(input int a, input int v);
      fl_regs_s t;
      t = exp_r;
      case (a)
         1: t.flash = 5'(v);
         2: t.torch = 5'(v);
         3: t.duration = 3'(v);
         4: t.low_batt = 4'(v);
         default: t.threshold = 5'(v);
      endcase
      note(t);
      host.frame(a, v);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      d = $urandom(6500);
      d = $urandom_range(7, 1);
      exp_r = '{flash: 5'h00, torch: 5'h00, duration: 3'h7, low_batt: 4'h0, threshold: 5'h05};
      repeat (10) @(posedge clk);
      #2 rst = 1'b0;
      host.level(1'b1, 10);
      check(32'(device_enabled), 32'h0000_0001);
      check(32'(reg_values), 32'(exp_r));
      wr(3, d);
      wr(5, 31);
      wr(2, 31);
      check(32'(torch_active), 32'h0000_0001);
      check(32'(led_current_ma), 32'h0000_012C);
      check(32'(boost_enable), 32'h0000_0001);
      wr(2, 0);
      check(32'(torch_active), 32'h0000_0000);
      check(32'(led_current_ma), 32'h0000_0000);
      wr(1, 31);
      check(32'(flash_active), 32'h0000_0001);
      check(32'(led_current_ma), 32'h0000_04B0);
      wr(1, 0);
      check(32'(flash_active), 32'h0000_0000);
      fe0 = fe_n;
      host.frame(3, 8); // discarded, duration must hold
      check(32'(fe_n), 32'(fe0 + 1));
      flash_trigger_pin = 1'b1;
      host.step(5);
      check(32'(flash_active), 32'h0000_0001);
      check(32'(led_current_ma), 32'h0000_03EE);
      check(32'(led_driver_on), 32'h0000_0001);
      check(32'(boost_enable), 32'h0000_0001);
      flash_trigger_pin = 1'b0;
      host.step(5);
      check(32'(flash_active), 32'h0000_0000);
      check(32'(boost_enable), 32'h0000_0000);
      wr(5, 1);
      flash_trigger_pin = 1'b1;
      n = 0;
      while (safety_expired !== 1'b1 && n < 1000) begin
         host.step(1);
         n++;
      end
      if (n >= 1000) begin
         err_total++;
      end else begin
         check(32'(n >= (d + 1) * STEP_CYC && n <= (d + 1) * STEP_CYC + 8), 32'h0000_0001);
      end
      host.step(3);
      check(32'(flash_active), 32'h0000_0000);
      check(32'(boost_enable), 32'h0000_0000);
      flash_trigger_pin = 1'b0;
      note('{flash: 5'h00, torch: 5'h00, duration: 3'h7, low_batt: 4'h0, threshold: 5'h05});
      host.level(1'b0, END_CYC + 20);
      check(32'(device_enabled), 32'h0000_0000);
      host.level(1'b1, 10);
      check(32'(device_enabled), 32'h0000_0001);
      host.step(5);
      check(32'(exp_q.size()), 32'h0000_0000);
      end_sim();
   end
endmodule

`default_nettype wire
